// file: src/sadc_pkg.sv
package sadc_pkg;

  // converter geometry
  localparam int RESULT_BITS     = 12;
  localparam int CFG_BITS        = 3;
  localparam int CNT_W           = 4;

  // fixed-input variant: falling shift-clock edge that enables the output
  localparam int FIXED_HOLD_FALL = 2;

  // configuration field positions after shifting (first bit lands highest)
  localparam int CFG_SGL_POS     = 2;
  localparam int CFG_POL_POS     = 1;
  localparam int CFG_ORDER_POS   = 0;

  // values after reset
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [2:0]  CFG_RST    = 3'h0;
  localparam logic [3:0]  CNT_RST    = 4'h0;

  // serial sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_START   = 7'h02,
    ST_CONFIG  = 7'h04,
    ST_ACQUIRE = 7'h08,
    ST_CONVERT = 7'h10,
    ST_LSB     = 7'h20,
    ST_ZERO    = 7'h40
  } sadc_state_t;

  // configuration word as received
  typedef struct packed {
    logic single_ended_select;
    logic polarity;
    logic order_select;
  } sadc_cfg_t;

  // analog multiplexer steering
  typedef struct packed {
    logic pos_chan_b;
    logic neg_chan_b;
    logic neg_ground;
  } sadc_mux_t;

  // serial output pin pair
  typedef struct packed {
    logic data;
    logic oe;
  } sadc_dout_t;

endpackage : sadc_pkg

// file: src/sadc_edge.sv
`timescale 1ns/1ps
module sadc_edge
  import sadc_pkg::*;
(
  // system
  input  wire logic clock,
  input  wire logic rst_b,
  // pins
  input  wire logic shift_clk,
  input  wire logic chip_select_n,
  // events
  output logic      clk_rise,
  output logic      clk_fall,
  output logic      sel_fall
);

  logic shift_clk_q;
  logic chip_select_n_q;

  // previous pin levels
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_clk_q     <= 1'b0;
      chip_select_n_q <= 1'b1;
    end else begin
      shift_clk_q     <= shift_clk;
      chip_select_n_q <= chip_select_n;
    end
  end

  // one-cycle edge pulses
  assign clk_rise = shift_clk & ~shift_clk_q;
  assign clk_fall = ~shift_clk & shift_clk_q;
  assign sel_fall = ~chip_select_n & chip_select_n_q;

endmodule : sadc_edge

// file: src/sadc_sar.sv
`timescale 1ns/1ps
module sadc_sar
  import sadc_pkg::*;
#(
  parameter int WIDTH = RESULT_BITS
)
(
  // system
  input  wire logic             clock,
  input  wire logic             rst_b,
  // control
  input  wire logic             clear,
  input  wire logic             decide,
  input  wire logic [CNT_W-1:0] bit_idx,
  input  wire logic             cmp_above,
  // values
  output logic      [WIDTH-1:0] trial_code,
  output logic      [WIDTH-1:0] result
);

  logic [WIDTH-1:0] result_q;

  // one-hot weight of the bit under trial
  function automatic logic [WIDTH-1:0] weight(input logic [CNT_W-1:0] idx);
    logic [WIDTH-1:0] w;
    w      = '0;
    w[idx] = 1'b1;
    return w;
  endfunction : weight

  // successive approximation: keep the trial bit when the input is above
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= '0;
    end else if (clear) begin
      result_q <= '0;
    end else if (decide && cmp_above) begin
      result_q <= result_q | weight(bit_idx);
    end
  end

  // code presented to the comparator
  assign trial_code = result_q | weight(bit_idx);
  assign result     = result_q;

endmodule : sadc_sar

// file: src/sadc_port.sv
`timescale 1ns/1ps
// Contract
// [RULE1] device is active with chip select low, powered down with it high
// [RULE2] bits launch on shift-clock falling edges, sampled on rising edges
// [RULE3] fixed variant: falling chip select starts a transfer, no configuration
// [RULE4] fixed variant: output enabled on second shift-clock pulse after select falls
// [RULE5] one null bit precedes the conversion result
// [RULE6] raising chip select resets the serial state for a fresh exchange
// [RULE7] fixed variant sends result MSB first, then LSB first
// [RULE8] host wanting MSB-first only may raise select after last bit
// [RULE9] two-channel: first sampled one is the start bit, leading zeros ignored
// [RULE10] a 3-bit configuration word follows the start bit and starts conversion
// [RULE11] later input bits are ignored until chip select cycles
// [RULE12] first two bits pick single-ended or differential channel pairing
// [RULE13] single-ended selection converts the chosen channel against ground
// [RULE14] order bit one: MSB-first result only, then zeros
// [RULE15] order bit zero: MSB-first result followed by LSB-first copy
// [RULE16] extra shift clocks after the transfer give zero bits indefinitely
// [RULE17] converter powers down at conversion end; clocking out continues
// [RULE18] result is 12-bit unipolar straight binary
// [RULE19] half duplex so input and output may share one wire
// [RULE20] host raises chip select at the end of each exchange
// [RULE21] shared wire: device drives low on fourth falling edge after start
// [RULE22] sampling starts before the order bit; hold at the following fall
// [RULE23] output is released while select is high and before enable point
// [RULE24] host holds select low throughout; early raise discards partial result
module sadc_port
  import sadc_pkg::*;
#(
  parameter bit TWO_CHAN = 1'b1,
  parameter int RES_W    = RESULT_BITS
)
(
  // system
  input  wire logic             clock,
  input  wire logic             rst_b,
  // serial link
  input  wire logic             chip_select_n,
  input  wire logic             shift_clk,
  input  wire logic             data_in,
  output sadc_dout_t            data_out,
  // analog front end
  input  wire logic             cmp_above,
  output logic      [RES_W-1:0] trial_code,
  output sadc_mux_t             mux_sel,
  output logic                  sample_track,
  output logic                  converter_power_on,
  output logic                  device_active,
  // status
  output sadc_cfg_t             cfg_word,
  output logic      [RES_W-1:0] result_code,
  output logic                  result_valid
);

  // parameters the counters cannot serve
  // the bit counter must reach the msb index and the three config bits
  // with a four-bit counter this caps the result at sixteen bits
  if (RES_W < 2 || RES_W > (1 << CNT_W)) begin : g_chk_res
    $error("result width out of range for bit counter");
  end
  if (CFG_BITS != 3) begin : g_chk_cfg
    $error("configuration word must be three bits");
  end
  if (FIXED_HOLD_FALL < 1 || FIXED_HOLD_FALL >= (1 << CNT_W)) begin : g_chk_hold
    $error("fixed hold fall out of range for bit counter");
  end

  // counter end points for each phase
  localparam logic [CNT_W-1:0] LAST_BIT  = CNT_W'(RES_W - 1);
  localparam logic [CNT_W-1:0] CFG_LAST  = CNT_W'(CFG_BITS - 1);
  localparam logic [CNT_W-1:0] CFG_TRACK = CNT_W'(CFG_BITS - 2);
  localparam logic [CNT_W-1:0] HOLD_FALL = CNT_W'(FIXED_HOLD_FALL);
  // fixed variant pairing: chan a positive, chan b negative
  localparam sadc_mux_t        FIXED_MUX = '{pos_chan_b: 1'b0, neg_chan_b: 1'b1, neg_ground: 1'b0};

  // counter step up, wraps within the counter width
  function automatic logic [CNT_W-1:0] step_up(input logic [CNT_W-1:0] v);
    return v + 1'b1;
  endfunction : step_up

  // counter step down for the msb-first walk
  function automatic logic [CNT_W-1:0] step_down(input logic [CNT_W-1:0] v);
    return v - 1'b1;
  endfunction : step_down

  // channel pairing from the configuration word
  // single-ended ties the negative side to ground
  function automatic sadc_mux_t decode_mux(input sadc_cfg_t c);
    sadc_mux_t m;
    m.pos_chan_b = c.polarity;
    m.neg_chan_b = ~c.single_ended_select & ~c.polarity;
    m.neg_ground = c.single_ended_select;
    return m;
  endfunction : decode_mux

  // internal state
  sadc_state_t      state_q;
  sadc_state_t      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  sadc_cfg_t        cfg_q;
  logic             lsb_follow_q;
  logic             dout_q;
  logic             oe_q;
  logic             track_q;
  logic             power_q;
  logic [RES_W-1:0] result_q;
  logic             valid_q;

  // edge events
  logic             clk_rise;
  logic             clk_fall;
  logic             sel_fall;
  logic             sel_high;

  // sar interface
  logic             sar_clear;
  logic             sar_decide;
  logic [RES_W-1:0] sar_result;

  // derived events
  logic             hold_edge;
  logic             last_conv;

  // select high is both shutdown and interface reset
  assign sel_high = chip_select_n; // [RULE1] [RULE6]

  // edge pulses of the sampled pins, one clock wide
  sadc_edge u_edge (
    .clock         (clock),
    .rst_b         (rst_b),
    .shift_clk     (shift_clk),
    .chip_select_n (chip_select_n),
    .clk_rise      (clk_rise),
    .clk_fall      (clk_fall),
    .sel_fall      (sel_fall)
  );

  // successive approximation register
  sadc_sar #(
    .WIDTH (RES_W)
  ) u_sar (
    .clock      (clock),
    .rst_b      (rst_b),
    .clear      (sar_clear),
    .decide     (sar_decide),
    .bit_idx    (cnt_q),
    .cmp_above  (cmp_above),
    .trial_code (trial_code),
    .result     (sar_result)
  );

  // hold edge: fixed variant on second fall, two-channel on fall after order bit
  // the same fall that ends tracking enables the driver and launches the null bit,
  // so a shared data wire is taken over exactly at that edge
  assign hold_edge = (state_q == ST_ACQUIRE) && clk_fall &&
                     (TWO_CHAN ? 1'b1 : (cnt_q == HOLD_FALL - 1'b1)); // [RULE4] [RULE21] [RULE22]
  assign last_conv = (state_q == ST_CONVERT) && clk_fall && (cnt_q == '0);

  // conversion bits are decided on falling edges, one per shift clock
  // the decided bit and the launched bit come from the same comparator sample,
  // so the output never shows a bit that the register later disagrees with
  assign sar_clear  = hold_edge || sel_high; // [RULE24]
  assign sar_decide = (state_q == ST_CONVERT) && clk_fall; // [RULE2]

  // sequencer next state
  // chip select high overrides every state so an aborted exchange leaves no residue
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      ST_IDLE: begin
        if (sel_fall) begin
          state_d = TWO_CHAN ? ST_START : ST_ACQUIRE; // [RULE3]
          cnt_d   = '0;
        end
      end
      ST_START: begin
        // leading zeros keep the sequencer waiting
        if (clk_rise && data_in) begin
          state_d = ST_CONFIG; // [RULE9]
          cnt_d   = '0;
        end
      end
      ST_CONFIG: begin
        // three rises fill the configuration word
        if (clk_rise) begin
          cnt_d = step_up(cnt_q);
          if (cnt_q == CFG_LAST) begin
            state_d = ST_ACQUIRE; // [RULE10] [RULE11]
            cnt_d   = '0;
          end
        end
      end
      ST_ACQUIRE: begin
        // fixed variant counts falls up to the hold point
        if (hold_edge) begin
          state_d = ST_CONVERT;
          cnt_d   = LAST_BIT;
        end else if (clk_fall) begin
          cnt_d = step_up(cnt_q);
        end
      end
      ST_CONVERT: begin
        // twelve decisions, msb down to bit zero
        if (clk_fall) begin
          cnt_d = step_down(cnt_q);
          if (cnt_q == '0) begin
            state_d = lsb_follow_q ? ST_LSB : ST_ZERO; // [RULE14] [RULE15]
            cnt_d   = CNT_W'(1);
          end
        end
      end
      ST_LSB: begin
        // eleven bits climbing from bit one
        if (clk_fall) begin
          cnt_d = step_up(cnt_q);
          if (cnt_q == LAST_BIT) begin
            state_d = ST_ZERO;
            cnt_d   = '0;
          end
        end
      end
      ST_ZERO: begin
        state_d = ST_ZERO; // [RULE16]
      end
    endcase
    if (sel_high) begin
      state_d = ST_IDLE; // [RULE6]
      cnt_d   = '0;
    end
  end

  // sequencer registers
  // the counter doubles as bit index during conversion and the lsb copy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q   <= CNT_RST;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // configuration word capture, first bit lands in the highest field
  // only the config state shifts, so later input bits never disturb the word
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= CFG_RST;
    end else if (state_q == ST_CONFIG && clk_rise) begin
      cfg_q <= {cfg_q[CFG_BITS-2:0], data_in}; // [RULE2] [RULE10] [RULE11]
    end
  end

  // output order: fixed variant always appends the LSB-first copy
  // the lsb-first copy starts at bit one because bit zero closes the msb-first run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lsb_follow_q <= 1'b1;
    end else if (sel_fall) begin
      lsb_follow_q <= 1'b1; // [RULE7]
    end else if (state_q == ST_CONFIG && clk_rise && cnt_q == CFG_LAST) begin
      lsb_follow_q <= TWO_CHAN ? ~data_in : 1'b1; // [RULE14] [RULE15]
    end
  end

  // input sample window
  // fixed variant tracks from select fall; two-channel from the bit before the order bit
  // cleared by the hold fall or by select high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      track_q <= 1'b0;
    end else if (sel_high || hold_edge) begin
      track_q <= 1'b0; // [RULE22]
    end else if (!TWO_CHAN && state_q == ST_IDLE && sel_fall) begin
      track_q <= 1'b1;
    end else if (state_q == ST_CONFIG && clk_rise && cnt_q == CFG_TRACK) begin
      track_q <= 1'b1; // [RULE22]
    end
  end

  // converter bias: on while select is low until the last bit is decided
  // the bias drops on the last decision so clocking out the tail costs no converter power
  // a mid-transfer abort also drops the bias at once
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_q <= 1'b0;
    end else if (sel_high || last_conv) begin
      power_q <= 1'b0; // [RULE1] [RULE17]
    end else if (sel_fall) begin
      power_q <= 1'b1; // [RULE1]
    end
  end

  // serial output: launched only on falling shift-clock edges
  // a launch away from a fall would race the host's rising-edge sample
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dout_q <= 1'b0;
      oe_q   <= 1'b0;
    end else if (sel_high) begin
      dout_q <= 1'b0; // [RULE23]
      oe_q   <= 1'b0;
    end else if (hold_edge) begin
      dout_q <= 1'b0; // [RULE5] [RULE21]
      oe_q   <= 1'b1; // [RULE4] [RULE19]
    end else if (clk_fall) begin
      unique case (state_q)
        ST_CONVERT: dout_q <= cmp_above; // [RULE7] [RULE18]
        ST_LSB:     dout_q <= sar_result[cnt_q]; // [RULE15]
        ST_ZERO:    dout_q <= 1'b0; // [RULE16]
        default:    dout_q <= 1'b0;
      endcase
    end
  end

  // completed result: updated only when all bits are decided
  // bit zero is folded in here because the sar register takes it on this same edge
  // result_valid drops at the next select fall, not at select rise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= RES_W'(RESULT_RST);
      valid_q  <= 1'b0;
    end else if (last_conv) begin
      result_q <= sar_result | (cmp_above ? RES_W'(1) : RES_W'(0)); // [RULE18]
      valid_q  <= 1'b1;
    end else if (sel_fall) begin
      valid_q  <= 1'b0; // [RULE24]
    end
  end

  // outward signals
  // all outputs except device_active, trial_code and mux_sel come straight from flip-flops
  assign data_out.data      = dout_q;
  assign data_out.oe        = oe_q;
  assign sample_track       = track_q;
  assign converter_power_on = power_q;
  assign device_active      = ~chip_select_n; // [RULE1]
  assign cfg_word           = cfg_q;
  assign result_code        = result_q;
  assign result_valid       = valid_q;

  // multiplexer steering; fixed variant is a single differential pair
  // steering follows the stored word, which stays put until the next exchange
  assign mux_sel = TWO_CHAN ? decode_mux(cfg_q) // [RULE12] [RULE13]
                            : FIXED_MUX;

endmodule : sadc_port

// file: verif/sadc_port_sva.sv
`timescale 1ns/1ps
module sadc_port_sva
  import sadc_pkg::*;
#(
  parameter bit TWO_CHAN = 1'b1
)
(
  // system
  input logic       clock,
  input logic       rst_b,
  // serial link
  input logic       chip_select_n,
  input logic       shift_clk,
  input sadc_dout_t data_out,
  // status
  input logic       sample_track,
  input logic       converter_power_on,
  input logic       device_active,
  input sadc_cfg_t  cfg_word,
  input logic       result_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic       sclk_q;
  logic [3:0] since_fall;
  logic [3:0] sel_falls;
  logic [4:0] bits_out;
  logic       fall_ev;
  logic       lsb_copy;
  // falls seen on the sampled shift clock, and whether a reversed copy follows
  assign fall_ev  = sclk_q & ~shift_clk;
  assign lsb_copy = ~TWO_CHAN | ~cfg_word.order_select;

  // age of last fall, falls since select, falls while driving
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q     <= 1'b0;
      since_fall <= 4'h0;
      sel_falls  <= 4'h0;
      bits_out   <= 5'h00;
    end else begin
      sclk_q     <= shift_clk;
      since_fall <= fall_ev ? 4'h0 : ((since_fall == 4'hf) ? since_fall : since_fall + 4'h1);
      sel_falls  <= chip_select_n ? 4'h0 : ((fall_ev && sel_falls != 4'hf) ? sel_falls + 4'h1 : sel_falls);
      bits_out   <= chip_select_n ? 5'h00 : ((fall_ev && data_out.oe && bits_out != 5'h1f) ? bits_out + 5'h01 : bits_out);
    end
  end

  property p_active; device_active == !chip_select_n; endproperty
  a_active: assert property (p_active) else $error("active flag wrong");
  property p_off; chip_select_n && $past(chip_select_n) && $past(chip_select_n, 2) |-> !converter_power_on && !data_out.oe; endproperty
  a_off: assert property (p_off) else $error("not idle while deselected");
  property p_null; $rose(data_out.oe) |-> !data_out.data; endproperty
  a_null: assert property (p_null) else $error("first driven bit not null");
  property p_fixed_en; $rose(data_out.oe) |-> TWO_CHAN || sel_falls == 4'h2; endproperty
  a_fixed_en: assert property (p_fixed_en) else $error("output enabled on wrong fall");
  property p_launch; !chip_select_n && data_out.oe && $past(data_out.oe) && $changed(data_out.data) |-> since_fall <= 4'h2; endproperty
  a_launch: assert property (p_launch) else $error("data changed away from a fall");
  property p_tail; data_out.oe && since_fall == 4'h3 && bits_out >= (lsb_copy ? 5'h18 : 5'h0d) |-> !data_out.data; endproperty
  a_tail: assert property (p_tail) else $error("nonzero bit after transfer");
  property p_cfg_hold; data_out.oe && $past(data_out.oe) |-> $stable(cfg_word); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed during output");
  property p_hold_point; $fell(sample_track) && !chip_select_n |-> ##[0:1] data_out.oe; endproperty
  a_hold_point: assert property (p_hold_point) else $error("hold without output enable");
  property p_auto_off; $rose(result_valid) |-> ##[0:1] !converter_power_on; endproperty
  a_auto_off: assert property (p_auto_off) else $error("converter still on after result");
  c_done: cover property ($rose(result_valid));
  c_copy: cover property (bits_out == 5'h18 && lsb_copy);
  c_abort: cover property ($rose(chip_select_n) && !result_valid);
endmodule : sadc_port_sva

bind sadc_port sadc_port_sva #(.TWO_CHAN(TWO_CHAN)) sadc_port_sva_i (.clock, .rst_b, .chip_select_n, .shift_clk,
  .data_out, .sample_track, .converter_power_on, .device_active, .cfg_word, .result_valid);

// file: verif/sadc_host.sv
`timescale 1ns/1ps
module sadc_host
  import sadc_pkg::*;
#(
  parameter int HALF = 3
)
(
  // system
  input  wire logic clock,
  // link out
  output logic       chip_select_n,
  output logic       shift_clk,
  output logic       data_in,
  // data back
  input  sadc_dout_t dout_a,
  input  sadc_dout_t dout_b
);
  // deselected, shift clock parked low
  initial begin
    chip_select_n = 1'b1;
    shift_clk     = 1'b0;
    data_in       = 1'b0;
  end

  // one exchange: zeros, start, config, then a toggling line once released
  task automatic xfer(input logic [2:0] c, input int lead, input int nrise, output logic [63:0] rx_a,
                      output logic [63:0] rx_b);
    int   k;
    logic b;
    rx_a = '0;
    rx_b = '0;
    @(posedge clock);
    chip_select_n <= 1'b0;
    for (k = 0; k < nrise; k++) begin
      b = (k < lead) ? 1'b0 : (k == lead) ? 1'b1 : (k <= lead + 3) ? c[lead + 3 - k] : k[0];
      @(posedge clock);
      data_in <= b;
      repeat (HALF) @(posedge clock);
      shift_clk <= 1'b1;
      rx_a[k] = dout_a.data;
      rx_b[k] = dout_b.data;
      repeat (HALF) @(posedge clock);
      shift_clk <= 1'b0;
    end
    repeat (HALF) @(posedge clock);
    chip_select_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : xfer
endmodule : sadc_host

// file: verif/test_serial_adc_interface.sv
`timescale 1ns/1ps
module test_serial_adc_interface
  import sadc_pkg::*;
;
  logic        clock, rst_b, chip_select_n, shift_clk, data_in;
  logic        cmp_a, cmp_b, val_a, val_b;
  logic [11:0] trial_a, trial_b, res_a, res_b;
  sadc_mux_t   mux_a, mux_b;
  sadc_dout_t  dout_a, dout_b;
  int          ch_a, ch_b, seed, n_fail, tests_run;

  // held input difference as the mux steers it
  function automatic int analog(input sadc_mux_t m, input int a, input int b);
    return (m.pos_chan_b ? b : a) - (m.neg_ground ? 0 : (m.neg_chan_b ? b : a));
  endfunction : analog
  assign cmp_a = analog(mux_a, ch_a, ch_b) >= int'(trial_a);
  assign cmp_b = analog(mux_b, ch_a, ch_b) >= int'(trial_b);

  sadc_port #(.TWO_CHAN(1'b1)) sadc_port_i (.clock(clock), .rst_b(rst_b), .chip_select_n(chip_select_n),
    .shift_clk(shift_clk), .data_in(data_in), .data_out(dout_a), .cmp_above(cmp_a), .trial_code(trial_a),
    .mux_sel(mux_a), .sample_track(), .converter_power_on(), .device_active(), .cfg_word(), .result_code(res_a),
    .result_valid(val_a));
  sadc_port #(.TWO_CHAN(1'b0)) sadc_port_fx_i (.clock(clock), .rst_b(rst_b), .chip_select_n(chip_select_n),
    .shift_clk(shift_clk), .data_in(data_in), .data_out(dout_b), .cmp_above(cmp_b), .trial_code(trial_b),
    .mux_sel(mux_b), .sample_track(), .converter_power_on(), .device_active(), .cfg_word(), .result_code(res_b),
    .result_valid(val_b));
  sadc_host sadc_host_i (.clock(clock), .chip_select_n(chip_select_n), .shift_clk(shift_clk), .data_in(data_in),
    .dout_a(dout_a), .dout_b(dout_b));

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // unipolar code for a config, clipped at zero
  function automatic logic [11:0] exp_code(input logic [2:0] c, input int a, input int b);
    int v;
    v = c[2] ? (c[1] ? b : a) : (c[1] ? b - a : a - b);
    return (v < 0) ? 12'h000 : v[11:0];
  endfunction : exp_code

  // bit at rise k: null, msb first, optional lsb-first copy, zeros
  function automatic logic exp_bit(input int k, input int n0, input logic [11:0] r, input logic lsb);
    if (k == n0) return 1'b0;
    if (k <= n0 + 12) return r[n0 + 12 - k];
    if (lsb && k <= n0 + 23) return r[k - n0 - 12];
    return 1'b0;
  endfunction : exp_bit

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one exchange on both variants and its comparisons
  task automatic run(input logic [2:0] c, input int lead, input int nrise);
    logic [63:0] rx_a, rx_b;
    logic [11:0] na, nb, ea, eb;
    logic        full;
    int          k;
    full = nrise > lead + 20;
    na = exp_code(c, ch_a, ch_b);
    nb = exp_code(3'h0, ch_a, ch_b);
    ea = full ? na : res_a;
    eb = full ? nb : res_b;
    sadc_host_i.xfer(c, lead, nrise, rx_a, rx_b);
    for (k = lead + 4; k < nrise; k++) check("bit two-channel", rx_a[k], exp_bit(k, lead + 4, na, ~c[0]));
    for (k = 2; k < nrise; k++) check("bit fixed", rx_b[k], exp_bit(k, 2, nb, 1'b1));
    check("result two-channel", res_a, ea);
    check("result fixed", res_b, eb);
    check("valid", val_a, full);
    check("valid fixed", val_b, nrise > 13);
  endtask : run

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // every config twice, first pass at code extremes, then abort and recovery
  initial begin
    int t;
    seed = 32'hf8d93a6b;
    rst_b = 1'b0;
    ch_a = 0;
    ch_b = 0;
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    for (t = 0; t < 16; t++) begin
      @(posedge clock);
      ch_a <= (t < 8) ? (t[0] ? 4095 : 0) : ($random(seed) & 32'hfff);
      ch_b <= (t < 8) ? (t[1] ? 4095 : 0) : ($random(seed) & 32'hfff);
      @(posedge clock);
      run(t[2:0], $random(seed) & 3, 40);
      $display("test %0d done", t);
    end
    run(3'h4, 1, 9);
    $display("abort test done");
    run(3'h5, 0, 40);
    $display("recovery test done");
    finish_test;
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    finish_test;
  end
endmodule : test_serial_adc_interface
